/* logic/pcs_midi_if.sv */
// Decoded link messages and channel filter setup between parser and core.
// Assumes both ends share one clock.
interface pcs_midi_if;
	logic [3:0] chan;     // Receive channel 0..15 = 1..16
	logic       omni;     // Accept every channel
	logic       pc_stb;   // Program change pulse
	logic [6:0] pc_num;   // Program number
	logic       cc7_stb;  // Volume controller pulse
	logic [6:0] cc7_val;  // Controller value

	modport rx (input chan, omni, output pc_stb, pc_num, cc7_stb, cc7_val);
	modport core (output chan, omni, input pc_stb, pc_num, cc7_stb, cc7_val);
endinterface : pcs_midi_if

/* logic/pcs_midi_rx.sv */
// Link byte parser: channel filter, program change and volume controller.
// Assumes one already-framed byte per midi_valid pulse, synchronous.
`include "pcs_regs.svh"

module pcs_midi_rx (
	input  wire logic       clk,         // System clock
	input  wire logic       rst_b,       // Synchronous reset, active low
	input  wire logic [7:0] midi_data,   // Received byte
	input  wire logic       midi_valid,  // Byte strobe
	pcs_midi_if.rx          mi           // Decoded messages
);
	import pcs_pkg::*;

	pcs_rx_state_type s;
	pcs_rx_state_type n;
	logic             ch_ok;

	// Parse bytes with running status; realtime bytes are ignored
	always_comb begin
		n = s;
		n.pc_stb = 1'b0;
		n.cc7_stb = 1'b0;
		ch_ok = mi.omni || (s.status[3:0] == mi.chan);
		if (midi_valid) begin
			if (midi_data[7]) begin
				if (midi_data[7:3] != 5'h1f) begin
					n.status = midi_data;
					n.have1 = 1'b0;
				end
			end else if (s.status[7] && ch_ok) begin
				if (s.status[7:4] == `PCS_MSG_PROG) begin
					n.pc_stb = 1'b1;
					n.pc_num = midi_data[6:0];
				end else if (s.status[7:4] == `PCS_MSG_CTRL) begin
					n.have1 = !s.have1;
					n.d1 = midi_data[6:0];
					if (s.have1 && s.d1 == `PCS_CC_VOLUME) begin
						n.cc7_stb = 1'b1;
						n.cc7_val = midi_data[6:0];
					end
				end
			end
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign mi.pc_stb = s.pc_stb;
	assign mi.pc_num = s.pc_num;
	assign mi.cc7_stb = s.cc7_stb;
	assign mi.cc7_val = s.cc7_val;

	AST_CHAN_FILTER: assert property (@(posedge clk) disable iff (!rst_b)
		midi_valid && !midi_data[7] && !ch_ok |=> !s.pc_stb && !s.cc7_stb)
		else $error("message on a foreign channel was accepted");

endmodule : pcs_midi_rx

/* logic/pcs_pkg.sv */
// Types shared by the preset copy/store controller modules.
// Assumes the constants header is on the include path.
package pcs_pkg;

	// Memory sequencer states
	typedef enum logic [2:0] {
		OP_BOOT,
		OP_IDLE,
		OP_LOAD,
		OP_CPY_RD,
		OP_WR
	} pcs_op_type;

	// State of the link message parser
	typedef struct packed {
		logic [7:0] status;   // Running status byte
		logic       have1;    // First data byte held
		logic [6:0] d1;       // First data byte
		logic       pc_stb;
		logic [6:0] pc_num;
		logic       cc7_stb;
		logic [6:0] cc7_val;
	} pcs_rx_state_type;

endpackage : pcs_pkg

/* logic/pcs_regs.svh */
// Constants of the preset copy/store controller: offsets, fields, timing.
// Assumes inclusion by bare name from the design modules.
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH

// Register byte offsets on the AXI4-Lite slave
`define PCS_REG_CONFIG   8'h00
`define PCS_REG_SETTINGS 8'h04
`define PCS_REG_STATUS   8'h08
`define PCS_REG_INT_STAT 8'h0c
`define PCS_REG_INT_MASK 8'h10

// CONFIG fields
`define PCS_CFG_CHAN_LSB  0
`define PCS_CFG_OMNI_BIT  4
`define PCS_CFG_MUTEN_BIT 5
`define PCS_CFG_FSW_BIT   6
`define PCS_RST_CHAN      4'h0
`define PCS_RST_OMNI      1'b1

// STATUS fields
`define PCS_ST_COPY_BIT   7
`define PCS_ST_EDIT_BIT   8
`define PCS_ST_ERR_BIT    9
`define PCS_ST_MUTE_BIT   10
`define PCS_ST_BUSY_BIT   11
`define PCS_ST_LED_BIT    12

// Interrupt bits
`define PCS_INT_LOADED    0
`define PCS_INT_COMMIT    1
`define PCS_INT_COPY_END  2
`define PCS_INT_MEM_ERR   3

// AXI responses
`define PCS_RESP_OKAY     2'h0
`define PCS_RESP_SLVERR   2'h2

// Link message codes and limits
`define PCS_MSG_PROG      4'hc
`define PCS_MSG_CTRL      4'hb
`define PCS_CC_VOLUME     7'h07
`define PCS_MUTE_MAX      7'h05

// Timing: clock, time base, durations in their own units
`define PCS_CLK_NS        10
`define PCS_TICK_NS       1000000
`define PCS_HOLD_MS       1000
`define PCS_COPY_S        30
`define PCS_ACK_DARK_MS   300
`define PCS_FAST_MS       100
`define PCS_BURST_MS      100
`define PCS_ERR_GAP_MS    600
`define PCS_EDIT_MS       250

`endif

/* logic/pcs_top.sv */
// Preset copy/store controller: AXI4-Lite registers, button, status LED,
// preset memory sequencer, link program change and volume mute.
// Assumes a nonvolatile store answering each request with one ack pulse.
//
// Summary of operation
// - Short press enters copy, takes current preset as source, LED steady.
// - Copy mode ends by itself thirty seconds after entry.
// - Hold in copy with new preset writes source contents there.
// - Any setting change during copy, until a hold starts the copy read, cancels it without writing.
// - Settings differing from stored ones make the LED flash regularly.
// - Flashing stops on reselecting the preset or after storing.
// - Memory fault shows as five short LED bursts.
// - Short press clears the error indication only.
// - Messages accepted only on selected channel 1..16, or all in omni.
// - Program numbers 0..127 each select one preset.
// - Volume controller acts on mute only when enabled.
// - Wired footswitch present blocks program change reception.
// - Holding one second outside copy stores settings into the preset.
// - Controller value 0..5 mutes, larger restores default level.
// - After power-up the first preset is recalled automatically.
//
// The register addresses and register access over AXI4-Lite were decided locally.
`include "pcs_regs.svh"

module pcs_top #(
	parameter int SET_W    = 16,                          // Settings width
	parameter int TICK_CYC = `PCS_TICK_NS / `PCS_CLK_NS,  // Cycles per ms
	parameter int HOLD_MS  = `PCS_HOLD_MS,                // Hold time
	parameter int COPY_MS  = `PCS_COPY_S * 1000           // Copy timeout
) (
	input  wire logic             clk,        // 100 MHz clock
	input  wire logic             rst_b,      // Sync reset, active low
	input  wire logic [7:0]       awaddr,     // AXI write address
	input  wire logic             awvalid,    // AXI write address valid
	output logic                  awready,    // AXI write address ready
	input  wire logic [31:0]      wdata,      // AXI write data
	input  wire logic [3:0]       wstrb,      // AXI byte strobes
	input  wire logic             wvalid,     // AXI write data valid
	output logic                  wready,     // AXI write data ready
	output logic [1:0]            bresp,      // AXI write response
	output logic                  bvalid,     // AXI response valid
	input  wire logic             bready,     // AXI response ready
	input  wire logic [7:0]       araddr,     // AXI read address
	input  wire logic             arvalid,    // AXI read address valid
	output logic                  arready,    // AXI read address ready
	output logic [31:0]           rdata,      // AXI read data
	output logic [1:0]            rresp,      // AXI read response
	output logic                  rvalid,     // AXI read valid
	input  wire logic             rready,     // AXI read ready
	input  wire logic [7:0]       midi_data,  // Link byte
	input  wire logic             midi_valid, // Link byte strobe
	input  wire logic             btn,        // Store/copy button, 1 = down
	output logic                  led,        // Status indicator
	output logic                  mute,       // Output silenced
	output logic [SET_W-1:0]      settings,   // Applied settings
	output logic                  nvm_req,    // Memory request level
	output logic                  nvm_we,     // Memory write
	output logic [6:0]            nvm_addr,   // Preset slot
	output logic [SET_W-1:0]      nvm_wdata,  // Memory write data
	input  wire logic             nvm_ack,    // Memory answer pulse
	input  wire logic             nvm_err,    // Memory fault with ack
	input  wire logic [SET_W-1:0] nvm_rdata,  // Memory read data
	output logic                  irq         // Interrupt level
);
	import pcs_pkg::*;

	typedef struct packed {
		pcs_op_type       op;
		logic [6:0]       preset;
		logic [6:0]       src;
		logic [6:0]       tgt;
		logic             pend;
		logic [6:0]       pend_num;
		logic [SET_W-1:0] cur;
		logic [SET_W-1:0] stored;
		logic             copy;
		logic [15:0]      copy_ms;
		logic             err;
		logic             mute;
		logic             btn_prev;
		logic             held;
		logic [15:0]      hold_ms;
		logic [31:0]      div;
		logic             tick;
		logic             ack_run;
		logic [3:0]       ph;
		logic [15:0]      led_ms;
		logic             led;
		logic [3:0]       chan;
		logic             omni;
		logic             mute_en;
		logic             fsw;
		logic [3:0]       ist;
		logic [3:0]       imask;
		logic             irq;
		logic             nvm_req;
		logic             nvm_we;
		logic [6:0]       nvm_addr;
		logic [SET_W-1:0] nvm_wdata;
		logic             aw_got;
		logic             w_got;
		logic [7:0]       aw_addr;
		logic [31:0]      w_data;
		logic [3:0]       w_strb;
		logic             awready;
		logic             wready;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             arready;
		logic             rvalid;
		logic [1:0]       rresp;
		logic [31:0]      rdata;
	} pcs_core_state_type;

	pcs_core_state_type s;
	pcs_core_state_type n;
	pcs_midi_if         mi ();

	logic        set_chg;
	logic        short_p;
	logic        long_p;
	logic        pc_in;
	logic        adv;
	logic        edited;
	logic [15:0] dur;
	logic [3:0]  ev;
	logic [3:0]  clr;
	logic [31:0] wv;
	logic [32:0] rd;

	pcs_midi_rx u_rx (
		.clk        (clk),
		.rst_b      (rst_b),
		.midi_data  (midi_data),
		.midi_valid (midi_valid),
		.mi         (mi)
	);

	assign mi.chan = s.chan;
	assign mi.omni = s.omni;
	assign edited = (s.cur != s.stored);

	// Register read mux; top bit flags an unmapped address
	function automatic logic [32:0] reg_rd(input logic [7:0] a);
		logic [31:0] v;
		v = '0;
		reg_rd = {1'b0, v};
		case (a)
			`PCS_REG_CONFIG: begin
				v[`PCS_CFG_CHAN_LSB +: 4] = s.chan;
				v[`PCS_CFG_OMNI_BIT] = s.omni;
				v[`PCS_CFG_MUTEN_BIT] = s.mute_en;
				v[`PCS_CFG_FSW_BIT] = s.fsw;
				reg_rd = {1'b0, v};
			end
			`PCS_REG_SETTINGS: reg_rd = {1'b0, 32'(s.cur)};
			`PCS_REG_STATUS: begin
				v[6:0] = s.preset;
				v[`PCS_ST_COPY_BIT] = s.copy;
				v[`PCS_ST_EDIT_BIT] = edited;
				v[`PCS_ST_ERR_BIT] = s.err;
				v[`PCS_ST_MUTE_BIT] = s.mute;
				v[`PCS_ST_BUSY_BIT] = (s.op != OP_IDLE);
				v[`PCS_ST_LED_BIT] = s.led;
				reg_rd = {1'b0, v};
			end
			`PCS_REG_INT_STAT: reg_rd = {1'b0, 28'h0, s.ist};
			`PCS_REG_INT_MASK: reg_rd = {1'b0, 28'h0, s.imask};
			default: reg_rd = {1'b1, 32'h0};
		endcase
	endfunction : reg_rd

	// Merge a written word into the old value by byte strobes
	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] w, input logic [3:0] st);
		for (int i = 0; i < 4; i++) begin
			o[i*8 +: 8] = st[i] ? w[i*8 +: 8] : o[i*8 +: 8];
		end
		merge = o;
	endfunction : merge

	// Whole next-state computation
	always_comb begin
		n = s;
		ev = '0;
		clr = '0;
		set_chg = 1'b0;
		short_p = 1'b0;
		long_p = 1'b0;
		rd = reg_rd(s.aw_addr);
		wv = merge(rd[31:0], s.w_data, s.w_strb);

		// Millisecond time base
		n.tick = 1'b0;
		if (s.div == 32'(TICK_CYC - 1)) begin
			n.div = '0;
			n.tick = 1'b1;
		end else begin
			n.div = s.div + 32'd1;
		end

		// Write channel: address and data in either order
		if (s.awready && awvalid) begin
			n.aw_got = 1'b1;
			n.aw_addr = awaddr;
		end
		if (s.wready && wvalid) begin
			n.w_got = 1'b1;
			n.w_data = wdata;
			n.w_strb = wstrb;
		end
		if (s.bvalid && bready) begin
			n.bvalid = 1'b0;
		end
		if (s.aw_got && s.w_got && !s.bvalid) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = rd[32] ? `PCS_RESP_SLVERR : `PCS_RESP_OKAY;
			case (s.aw_addr)
				`PCS_REG_CONFIG: begin
					n.chan = wv[`PCS_CFG_CHAN_LSB +: 4];
					n.omni = wv[`PCS_CFG_OMNI_BIT];
					n.mute_en = wv[`PCS_CFG_MUTEN_BIT];
					n.fsw = wv[`PCS_CFG_FSW_BIT];
				end
				`PCS_REG_SETTINGS: begin
					n.cur = wv[SET_W-1:0];
					set_chg = (wv[SET_W-1:0] != s.cur);
				end
				`PCS_REG_INT_STAT: clr = s.w_strb[0] ? s.w_data[3:0] : 4'h0;
				`PCS_REG_INT_MASK: n.imask = wv[3:0];
				default: n.bresp = n.bresp;
			endcase
		end
		n.awready = !n.aw_got && !n.bvalid;
		n.wready = !n.w_got && !n.bvalid;

		// Read channel: answer one cycle after the address is taken
		if (s.rvalid && rready) begin
			n.rvalid = 1'b0;
		end
		if (s.arready && arvalid) begin
			rd = reg_rd(araddr);
			n.rvalid = 1'b1;
			n.rdata = rd[31:0];
			n.rresp = rd[32] ? `PCS_RESP_SLVERR : `PCS_RESP_OKAY;
		end
		n.arready = !n.rvalid;

		// Button timing; a release before the hold time is a short press
		n.btn_prev = btn;
		if (btn) begin
			if (s.tick && s.hold_ms != 16'(HOLD_MS - 1)) begin
				n.hold_ms = s.hold_ms + 16'd1;
			end
			if (s.hold_ms == 16'(HOLD_MS - 1) && !s.held) begin
				long_p = 1'b1;
				n.held = 1'b1;
			end
		end else begin
			short_p = s.btn_prev && !s.held;
			n.hold_ms = '0;
			n.held = 1'b0;
		end

		// Copy window and cancellation
		if (s.copy && s.tick) begin
			n.copy_ms = s.copy_ms + 16'd1;
		end
		if (s.copy && s.copy_ms == 16'(COPY_MS - 1)) begin
			n.copy = 1'b0;
			ev[`PCS_INT_COPY_END] = 1'b1;
		end
		if (s.copy && set_chg) begin
			n.copy = 1'b0;
			ev[`PCS_INT_COPY_END] = 1'b1;
		end

		// Link messages; the latest program change waits for the sequencer
		pc_in = mi.pc_stb && !s.fsw;
		if (pc_in) begin
			n.pend = 1'b1;
			n.pend_num = mi.pc_num;
		end
		if (mi.cc7_stb && s.mute_en) begin
			n.mute = (mi.cc7_val <= `PCS_MUTE_MAX);
		end

		// Indicator patterns, highest first: done, error, copy, edited
		if (s.ack_run) begin
			dur = (s.ph == 4'd0) ? 16'(`PCS_ACK_DARK_MS) : 16'(`PCS_FAST_MS);
		end else if (s.err) begin
			dur = (s.ph == 4'd10) ? 16'(`PCS_ERR_GAP_MS) : 16'(`PCS_BURST_MS);
		end else begin
			dur = 16'(`PCS_EDIT_MS);
		end
		adv = s.tick && (s.led_ms >= dur - 16'd1);
		if (s.tick) begin
			n.led_ms = adv ? 16'd0 : s.led_ms + 16'd1;
			n.ph = adv ? s.ph + 4'd1 : s.ph;
		end
		if (s.ack_run) begin
			n.led = s.ph[0];
			if (adv && s.ph == 4'd6) begin
				n.ack_run = 1'b0;
				n.ph = '0;
			end
		end else if (s.err) begin
			n.led = (s.ph < 4'd10) && !s.ph[0];
			if (adv && s.ph == 4'd10) begin
				n.ph = '0;
			end
		end else if (s.copy) begin
			n.led = 1'b1;
		end else if (edited) begin
			n.led = s.ph[0];
		end else begin
			n.led = 1'b0;
		end

		// Button clears the error view; a new fault below still wins
		if (short_p && s.err) begin
			n.err = 1'b0;
		end

		// Preset memory sequencer
		unique case (s.op)
			OP_BOOT: begin
				n.nvm_req = 1'b1;
				n.nvm_we = 1'b0;
				n.nvm_addr = 7'h00;
				n.tgt = 7'h00;
				n.op = OP_LOAD;
			end
			OP_IDLE: begin
				if (s.pend) begin
					n.pend = pc_in;
					n.tgt = s.pend_num;
					n.nvm_req = 1'b1;
					n.nvm_we = 1'b0;
					n.nvm_addr = s.pend_num;
					n.op = OP_LOAD;
				end else if (long_p && s.copy) begin
					if (s.preset != s.src) begin
						n.nvm_req = 1'b1;
						n.nvm_we = 1'b0;
						n.nvm_addr = s.src;
						n.op = OP_CPY_RD;
					end
				end else if (long_p) begin
					n.nvm_req = 1'b1;
					n.nvm_we = 1'b1;
					n.nvm_addr = s.preset;
					n.nvm_wdata = s.cur;
					n.op = OP_WR;
				end else if (short_p && !s.err && !s.copy) begin
					n.copy = 1'b1;
					n.src = s.preset;
					n.copy_ms = '0;
				end
			end
			OP_LOAD: begin
				if (nvm_ack) begin
					n.nvm_req = 1'b0;
					n.op = OP_IDLE;
					if (nvm_err) begin
						n.err = 1'b1;
					end else begin
						n.cur = nvm_rdata;
						n.stored = nvm_rdata;
						n.preset = s.tgt;
						ev[`PCS_INT_LOADED] = 1'b1;
					end
				end
			end
			OP_CPY_RD: begin
				if (nvm_ack && nvm_err) begin
					n.nvm_req = 1'b0;
					n.err = 1'b1;
					n.copy = 1'b0;
					n.op = OP_IDLE;
				end else if (nvm_ack) begin
					n.nvm_we = 1'b1;
					n.nvm_addr = s.preset;
					n.nvm_wdata = nvm_rdata;
					n.cur = nvm_rdata;
					n.copy = 1'b0;
					n.op = OP_WR;
				end
			end
			OP_WR: begin
				if (nvm_ack) begin
					n.nvm_req = 1'b0;
					n.nvm_we = 1'b0;
					n.op = OP_IDLE;
					if (nvm_err) begin
						n.err = 1'b1;
					end else begin
						n.stored = s.nvm_wdata;
						n.ack_run = 1'b1;
						n.ph = '0;
						n.led_ms = '0;
						ev[`PCS_INT_COMMIT] = 1'b1;
					end
				end
			end
		endcase

		// Fault raises the error view with a fresh burst sequence
		if (n.err && !s.err) begin
			ev[`PCS_INT_MEM_ERR] = 1'b1;
			if (!n.ack_run) begin
				n.ph = '0;
				n.led_ms = '0;
			end
		end

		// Sticky events; a set in the clearing cycle survives
		n.ist = (s.ist & ~clr) | ev;
		n.irq = |(n.ist & n.imask);
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s <= '0;
			s.chan <= `PCS_RST_CHAN;
			s.omni <= `PCS_RST_OMNI;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from the state register
	assign awready = s.awready;
	assign wready = s.wready;
	assign bresp = s.bresp;
	assign bvalid = s.bvalid;
	assign arready = s.arready;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign rvalid = s.rvalid;
	assign led = s.led;
	assign mute = s.mute;
	assign settings = s.cur;
	assign nvm_req = s.nvm_req;
	assign nvm_we = s.nvm_we;
	assign nvm_addr = s.nvm_addr;
	assign nvm_wdata = s.nvm_wdata;
	assign irq = s.irq;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	AST_COPY_SRC: assert property ($rose(s.copy) |-> s.src == $past(s.preset))
		else $error("copy source is not the selected preset");
	AST_COPY_LED: assert property (s.copy && !s.err && !s.ack_run |=> led)
		else $error("indicator not steady in copy mode");
	AST_COPY_TIMEOUT: assert property (
		s.copy && s.copy_ms == 16'(COPY_MS - 1) |=> !s.copy)
		else $error("copy mode outlived its window");
	AST_COPY_COMMIT: assert property (
		s.op == OP_CPY_RD && nvm_ack && !nvm_err |=> s.op == OP_WR
		&& nvm_we && nvm_addr == $past(s.preset) && nvm_wdata == $past(nvm_rdata))
		else $error("copy did not write source data to target");
	AST_COPY_CANCEL: assert property (s.copy && set_chg |=> !s.copy)
		else $error("setting change did not cancel copy");
	AST_CLEAN_DARK: assert property (
		!edited && !s.copy && !s.err && !s.ack_run |=> !led)
		else $error("indicator lit with nothing to show");
	AST_MEM_ERR: assert property (s.nvm_req && nvm_ack && nvm_err |=> s.err)
		else $error("memory fault not indicated");
	AST_ERR_CLEAR: assert property (
		short_p && s.err && !(nvm_ack && nvm_err) |=> !s.err)
		else $error("button did not clear the error view");
	AST_PC_BLOCK: assert property (mi.pc_stb && s.fsw && !s.pend |=> !s.pend)
		else $error("program change taken with footswitch present");
	AST_MUTE_IGN: assert property (mi.cc7_stb && !s.mute_en |=> $stable(mute))
		else $error("volume controller acted while disabled");
	AST_MUTE_SET: assert property (mi.cc7_stb && s.mute_en
		|=> mute == ($past(mi.cc7_val) <= 7'h05))
		else $error("mute does not follow controller value");
	AST_STORE: assert property (
		long_p && s.op == OP_IDLE && !s.pend && !s.copy
		|=> s.op == OP_WR && nvm_we && nvm_wdata == $past(s.cur))
		else $error("hold did not store the settings");
	AST_BOOT: assert property (s.op == OP_BOOT
		|=> nvm_req && nvm_addr == 7'h00 && s.op == OP_LOAD ##[1:1000] s.ist[0])
		else $error("first preset not recalled at power-up");

	COV_COPY_DONE: cover property (s.op == OP_CPY_RD ##[1:50] s.op == OP_WR);
	COV_STORE_DONE: cover property (s.op == OP_WR && nvm_ack && !nvm_err);
	COV_ERR_CLEAR: cover property (s.err ##1 !s.err);

endmodule : pcs_top

/* testbench/pcs_foot_ctrl.sv */
// Foot controller model: sends link bytes one at a time.
// Assumes the caller starts send() just after a rising clock edge.
module pcs_foot_ctrl (
	input  wire logic       clk,        // System clock
	output logic [7:0]      midi_data,  // Link byte
	output logic            midi_valid  // Byte strobe
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		midi_data  = 8'h00;
		midi_valid = 1'b0;
	end

	// Inverse after the strobe, so a stale byte never passes for a new one
	task automatic send(input logic [7:0] b);
		midi_data  <= b;
		midi_valid <= 1'b1;
		@(posedge clk);
		midi_valid <= 1'b0;
		midi_data  <= ~b;
		@(posedge clk);
	endtask : send
endmodule : pcs_foot_ctrl

/* testbench/pcs_top_tb.sv */
// Bench for the preset copy/store controller with a preset memory model.
// Assumes the short counts TICK_CYC=10, HOLD_MS=5, COPY_MS=40.
module pcs_top_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready, btn, bad;
	logic awready, wready, bvalid, arready, rvalid, led, mute, irq;
	logic nvm_req, nvm_we, nvm_ack, nvm_err, midi_valid;
	logic [7:0]  awaddr, araddr, midi_data;
	logic [7:0]  pg [3];
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [15:0] settings, nvm_wdata, nvm_rdata, v;
	logic [15:0] mem [128];
	logic [6:0]  nvm_addr;
	logic [65:0] q [$];
	logic [65:0] e;
	logic [33:0] mk;
	int          num_errors, checked, dly, i;

	pcs_top #(.TICK_CYC(10), .HOLD_MS(5), .COPY_MS(40)) dut (.clk, .rst_b,
		.awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .midi_data, .midi_valid, .btn, .led,
		.mute, .settings, .nvm_req, .nvm_we, .nvm_addr, .nvm_wdata,
		.nvm_ack, .nvm_err, .nvm_rdata, .irq);
	pcs_foot_ctrl fc (.clk, .midi_data, .midi_valid);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Memory answers three cycles late; read data is scrambled between acks
	always @(posedge clk) begin
		nvm_ack <= 1'b0;
		nvm_err <= 1'b0;
		nvm_rdata <= ~nvm_rdata;
		if (nvm_req && !nvm_ack) begin
			dly <= dly + 1;
			if (dly == 2) begin
				dly <= 0;
				nvm_ack <= 1'b1;
				nvm_err <= bad;
				nvm_rdata <= mem[nvm_addr];
				if (nvm_we && !bad) mem[nvm_addr] <= nvm_wdata;
			end
		end
	end

	task automatic chk(input string n, input logic [33:0] x, got);
		checked++;
		if (got !== x) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, x, got);
		end
	endtask : chk

	// Oldest read note against each read answer
	always @(posedge clk) begin
		if (rvalid && rready) begin
			e = q.pop_front();
			mk = {2'h3, e[65:34]};
			chk("rdata", e[33:0] & mk, {rresp, rdata} & mk);
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				chk("bresp", 34'h0, 34'(bresp));
			end
		end while (bready);
	endtask : wr

	// Offsets above 0x10 are expected to answer with an error response
	task automatic rd(input logic [7:0] a, input logic [31:0] x, m);
		q.push_back({m, ((a > 8'h10) ? 2'h2 : 2'h0), x});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) rready <= 1'b0;
		end while (rready);
	endtask : rd

	task automatic idle;
		int k;
		repeat (6) @(posedge clk);
		for (k = 0; k < 200 && nvm_req; k++) @(posedge clk);
		@(posedge clk);
	endtask : idle

	task automatic msg(input logic [7:0] s, d);
		fc.send(s);
		fc.send(d);
		idle();
	endtask : msg

	task automatic press(input int n);
		btn <= 1'b1;
		repeat (n) @(posedge clk);
		btn <= 1'b0;
		idle();
	endtask : press

	task automatic report_and_stop;
		$display("checked %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : report_and_stop

	// Watchdog: the whole sequence needs well under this
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		report_and_stop();
	end

	initial begin
		{rst_b, awvalid, wvalid, bready, arvalid, rready, btn, bad} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		void'($urandom(32'h8b1f4dba));
		foreach (mem[j]) mem[j] = 16'($urandom);
		pg = '{8'h7f, 8'($urandom_range(126, 1)), 8'h00};
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		idle();
		rd(8'h08, 32'h0, 32'h7f);
		rd(8'h04, {16'h0, mem[0]}, 32'hffff);
		chk("settings", {18'h0, mem[0]}, {18'h0, settings});
		rd(8'h00, 32'h10, 32'h7f);
		rd(8'h14, 32'h0, '1);
		$display("test boot done");
		wr(8'h00, 32'h3);
		foreach (pg[j]) begin
			msg(8'hc3, pg[j]);
			rd(8'h08, {24'h0, pg[j]}, 32'h7f);
		end
		msg(8'hc2, 8'h0a);
		rd(8'h08, 32'h0, 32'h7f);
		wr(8'h00, 32'h13);
		msg(8'hc5, 8'h0c);
		rd(8'h08, 32'h0c, 32'h7f);
		wr(8'h00, 32'h43);
		msg(8'hc3, 8'h0b);
		rd(8'h08, 32'h0c, 32'h7f);
		$display("test program done");
		// Disabled, then mute at the top value, then restore just above
		for (i = 0; i < 3; i++) begin
			wr(8'h00, (i != 0) ? 32'h23 : 32'h03);
			fc.send(8'hb3);
			msg(8'h07, 8'(i + 4));
			rd(8'h08, {21'h0, i == 1, 10'h0}, 32'h400);
			chk("mute", 34'(i == 1), 34'(mute));
		end
		$display("test mute done");
		msg(8'hc3, 8'h14);
		press(20);
		rd(8'h08, 32'h1080, 32'h1080);
		chk("led", 34'h1, 34'(led));
		msg(8'hc3, 8'h15);
		press(60);
		chk("copy", {18'h0, mem[20]}, {18'h0, mem[21]});
		rd(8'h08, 32'h15, 32'hff);
		press(20);
		wr(8'h04, {16'h0, ~mem[21]});
		rd(8'h08, 32'h100, 32'h180);
		msg(8'hc3, 8'h15);
		rd(8'h08, 32'h0, 32'h100);
		press(20);
		repeat (350) @(posedge clk);
		rd(8'h08, 32'h80, 32'h80);
		repeat (80) @(posedge clk);
		rd(8'h08, 32'h0, 32'h80);
		$display("test copy done");
		v = ~mem[21];
		wr(8'h04, {16'h0, v});
		rd(8'h08, 32'h100, 32'h100);
		press(60);
		chk("store", {18'h0, v}, {18'h0, mem[21]});
		rd(8'h08, 32'h0, 32'h100);
		$display("test store done");
		wr(8'h0c, 32'hf);
		wr(8'h10, 32'h8);
		bad <= 1'b1;
		msg(8'hc3, 8'h01);
		bad <= 1'b0;
		rd(8'h08, 32'h200, 32'h200);
		chk("irq", 34'h1, 34'(irq));
		press(20);
		rd(8'h08, 32'h0, 32'h200);
		wr(8'h0c, 32'h8);
		repeat (2) @(posedge clk);
		chk("irq", 34'h0, 34'(irq));
		$display("test error done");
		report_and_stop();
	end
endmodule : pcs_top_tb
